// File: rtl/rtc_ctl_if.sv
`timescale 1ns/100ps
interface rtc_ctl_if;
    logic        stamp_clear;
    logic        stamp_load;
    logic [15:0] load_val;
    logic        test_tick;
    logic        ext_tick;
    logic [2:0]  res;
    logic [15:0] stamp_val;
    logic        irq_event;
    logic        level_mode;
    logic        irq_release;
    logic        int_n;

    modport ctrl  (output stamp_clear, stamp_load, load_val, test_tick, ext_tick, res,
                   irq_event, level_mode, irq_release, input stamp_val, int_n);
    modport stamp (input stamp_clear, stamp_load, load_val, test_tick, ext_tick, res, output stamp_val);
    modport irq   (input irq_event, level_mode, irq_release, output int_n);
endinterface

// File: rtl/rtc_irq.sv
`timescale 1ns/100ps
module rtc_irq
    import rtc_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    input  logic    clk,
    input  logic    reset,
    rtc_ctl_if.irq  ctl
);
    if (PULSE_CYCLES < 8 || PULSE_CYCLES > 31) begin : g_bad_pulse
        $error("PULSE_CYCLES out of range 8..31");
    end

    typedef struct packed {
        logic       int_n;
        logic [4:0] cnt;
    } rtc_irq_st_t;

    rtc_irq_st_t st;
    rtc_irq_st_t next_st;

    always_comb begin
        next_st = st;
        // a new request wins over a release in the same cycle
        if (ctl.irq_event) begin
            next_st.int_n = 1'b0;
            next_st.cnt   = 5'(PULSE_CYCLES - 1);
        end else if (ctl.level_mode) begin
            next_st.cnt = 5'h00;
            if (ctl.irq_release) begin
                next_st.int_n = 1'b1;
            end
        end else if (st.cnt != 5'h00) begin
            next_st.cnt = st.cnt - 5'h01;
        end else begin
            next_st.int_n = 1'b1;
        end
    end

    // pin kept as a flop of its own, idle high
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '{int_n: 1'b1, cnt: 5'h00};
        end else begin
            st <= next_st;
        end
    end

    assign ctl.int_n = st.int_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_pulse_start;
        !ctl.level_mode && ctl.irq_event;
    endsequence
    sequence s_pulse_last;
        !ctl.level_mode && !ctl.int_n && st.cnt == 5'h00 && !ctl.irq_event;
    endsequence

    AST_PULSE_LOW: assert property (s_pulse_start |=> !ctl.int_n [*8])
        else $error("interrupt pulse too short");
    AST_PULSE_END: assert property (s_pulse_last |=> ctl.int_n)
        else $error("interrupt pulse too long");
    AST_LEVEL_HOLD: assert property (
        ctl.level_mode && !ctl.int_n && !ctl.irq_release |=> !ctl.int_n) else $error("level interrupt dropped");
    AST_LEVEL_FREE: assert property (
        ctl.level_mode && ctl.irq_release && !ctl.irq_event |=> ctl.int_n) else $error("level not released");
endmodule

// File: rtl/rtc_pkg.sv
// How it works
// - test resolution: stamp advances only on each host test-clock command
// - RT mode, sync-clear set: Synchronize without data zeroes the stamp
// - RT mode, sync-load set: Synchronize with data loads its word
// - BC mode, sync-load set: stamp is sent as Synchronize data word
// - enhanced sync set: sent word is the live 16-bit stamp
// - auto-clear: reading a status register clears only that register
// - auto-clear plus level: interrupt released once all active registers read
// - pulse mode: each request is a low pulse of about 500 ns
// - level mode: interrupt held low until auto-clear read or reset command
// - auto service-request clear off: only host writes change the flag
// - auto clear on: flag set through vector response, then self-clears
// - basic memory mode: single buffers, receive double only when enabled
// - enhanced plus receive double, basic memory mode: all receive subaddresses double buffered
// - single mode reuses one data block per subaddress
// - enhanced memory: per-subaddress single, double or circular 128..8192
// - transmit subaddresses never double buffered
// - enhanced plus global circular: receive may pick the shared buffer
// - separate-broadcast off: broadcast pointers from receive area
// - separate-broadcast on: broadcast pointers from broadcast area
// - resolution codes 0..5 give 64..2 us, 6 test, 7 external
package rtc_pkg;
    // ==========================================================
    // register map
    localparam logic [3:0]  REG_CFG      = 4'h0;
    localparam logic [3:0]  REG_CMD      = 4'h1;
    localparam logic [3:0]  REG_CFG_EXT  = 4'h2;
    localparam logic [3:0]  REG_STAMP    = 4'h3;
    localparam logic [3:0]  REG_ISR1     = 4'h4;
    localparam logic [3:0]  REG_ISR2     = 4'h5;
    // ==========================================================
    // configuration fields
    localparam int          CFG_RXDBUF   = 12;
    localparam int          CFG_RES_LSB  = 7;
    localparam int          CFG_SYNC_CLR = 6;
    localparam int          CFG_SYNC_LD  = 5;
    localparam int          CFG_AUTOCLR  = 4;
    localparam int          CFG_LEVEL    = 3;
    localparam int          CFG_CLRSRQ   = 2;
    localparam int          CFG_ENHMM    = 1;
    localparam int          CFG_SEPBC    = 0;
    localparam logic [15:0] CFG_MASK     = 16'h13FF;
    localparam logic [15:0] CFG_RESET    = 16'h0000;
    localparam int          EXT_ENH      = 15;
    localparam int          EXT_GCIRC    = 12;
    localparam int          EXT_ENHSYNC  = 2;
    localparam int          EXT_SRQ      = 0;
    localparam logic [15:0] EXT_MASK     = 16'h9005;
    localparam logic [15:0] EXT_RESET    = 16'h0000;
    // ==========================================================
    // command bits
    localparam int          CMD_TEST_CLK = 4;
    localparam int          CMD_STAMP_RST = 3;
    localparam int          CMD_INT_RST  = 2;
    // ==========================================================
    // timing
    localparam logic [2:0]  RES_TEST     = 3'h6;
    localparam logic [2:0]  RES_EXT      = 3'h7;
    localparam int          CLK_MHZ      = 25;
    localparam int          STAMP_US_MAX = 64;
    localparam int          PULSE_NS     = 500;
    localparam int          PULSE_CYC    = (PULSE_NS * CLK_MHZ / 1000 < 1) ? 1 : PULSE_NS * CLK_MHZ / 1000;
    localparam logic [3:0]  CIRC_LOG2_BASE = 4'h6;
    // ==========================================================
    // types
    typedef enum logic [1:0] {RTC_BUF_SINGLE, RTC_BUF_DOUBLE, RTC_BUF_CIRC, RTC_BUF_GLOBAL} rtc_buf_t;
    typedef enum logic [1:0] {RTC_AREA_TX, RTC_AREA_RX, RTC_AREA_BCST} rtc_area_t;

    // clock cycles per stamp count for a resolution code
    function automatic int rtc_stamp_div(input logic [2:0] res);
        return (STAMP_US_MAX >> res) * CLK_MHZ;
    endfunction
endpackage

// File: rtl/rtc_stamp.sv
`timescale 1ns/100ps
module rtc_stamp
    import rtc_pkg::*;
#(
    parameter int DIV_W = 11
) (
    input  logic      clk,
    input  logic      reset,
    rtc_ctl_if.stamp  ctl
);
    if (2 ** DIV_W <= rtc_stamp_div(3'h0)) begin : g_bad_div
        $error("DIV_W too small for the slowest resolution");
    end

    typedef struct packed {
        logic [DIV_W-1:0] pre;
        logic [15:0]      cnt;
    } rtc_stamp_st_t;

    rtc_stamp_st_t    st;
    rtc_stamp_st_t    next_st;
    logic [DIV_W-1:0] div_last;

    assign div_last = DIV_W'(rtc_stamp_div(ctl.res) - 1);

    always_comb begin
        next_st = st;
        if (ctl.stamp_clear) begin
            next_st.cnt = 16'h0000;
            next_st.pre = '0;
        end else if (ctl.stamp_load) begin
            next_st.cnt = ctl.load_val;
            next_st.pre = '0;
        end else if (ctl.res == RES_TEST) begin
            if (ctl.test_tick) begin
                next_st.cnt = st.cnt + 16'h0001;
            end
        end else if (ctl.res == RES_EXT) begin
            if (ctl.ext_tick) begin
                next_st.cnt = st.cnt + 16'h0001;
            end
        end else if (st.pre >= div_last) begin
            next_st.pre = '0;
            next_st.cnt = st.cnt + 16'h0001;
        end else begin
            next_st.pre = st.pre + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ctl.stamp_val = st.cnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_TEST_ONLY: assert property (
        ctl.res == RES_TEST && !ctl.test_tick && !ctl.stamp_clear && !ctl.stamp_load
        |=> $stable(ctl.stamp_val)) else $error("stamp moved without test clock");
    AST_TEST_STEP: assert property (
        ctl.res == RES_TEST && ctl.test_tick && !ctl.stamp_clear && !ctl.stamp_load
        |=> ctl.stamp_val == $past(ctl.stamp_val) + 16'h0001) else $error("test clock did not step stamp");
    AST_PRE_RANGE: assert property (
        ctl.res < RES_TEST && $stable(ctl.res) |-> st.pre <= div_last) else $error("divider overran");
endmodule

// File: rtl/rtc_top.sv
`timescale 1ns/100ps
module rtc_top
    import rtc_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    input  logic        MCLK,
    input  logic        RESET,
    input  logic [3:0]  ADDR,
    input  logic [15:0] WDATA,
    input  logic        WR,
    input  logic        RD,
    output logic [15:0] RDATA,
    input  logic        RT_MODE,
    input  logic        MSG_START,
    input  logic        SYNC_NODATA,
    input  logic        SYNC_DATA,
    input  logic [15:0] SYNC_WORD,
    input  logic        TVW_DONE,
    input  logic        IRQ_EVENT,
    input  logic [15:0] ISR1_DATA,
    input  logic [15:0] ISR2_DATA,
    input  logic        EXT_STAMP_CLK,
    input  logic        SA_TX,
    input  logic        SA_BCST,
    input  logic [2:0]  SA_MM,
    input  logic        SA_DBUF,
    input  logic        SA_GLOBAL,
    output logic        INT_N,
    output logic        ISR1_CLR,
    output logic        ISR2_CLR,
    output logic        ISR_RESET,
    output logic        SRQ_STATUS,
    output logic        BC_SYNC_STAMP,
    output logic [15:0] BC_SYNC_WORD,
    output rtc_buf_t    BUF_MODE,
    output logic [3:0]  CIRC_LOG2,
    output rtc_area_t   LUT_AREA
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] ext;
        logic [15:0] msg_cfg;
        logic [15:0] msg_ext;
        logic [15:0] msg_stamp;
        logic [15:0] rdata;
        logic        isr1_clr;
        logic        isr2_clr;
        logic        isr_reset;
        logic        seen1;
        logic        seen2;
        logic        bc_stamp;
        logic [15:0] bc_word;
        rtc_buf_t    buf_mode;
        logic [3:0]  circ_log2;
        rtc_area_t   area;
        logic [2:0]  ext_sync;
    } rtc_top_st_t;

    rtc_top_st_t st;
    rtc_top_st_t next_st;
    rtc_ctl_if   ctl ();

    logic cmd_wr;
    logic rd_isr1;
    logic rd_isr2;
    logic auto_release;
    logic seen1;
    logic seen2;

    // ==========================================================
    // buffer mode selection per subaddress
    function automatic rtc_buf_t buf_pick(input logic [15:0] cfg, input logic [15:0] ext, input logic tx,
                                          input logic [2:0] mm, input logic dbuf, input logic glob);
        rtc_buf_t mode;
        mode = RTC_BUF_SINGLE;
        if (!cfg[CFG_ENHMM]) begin
            if (!tx && ext[EXT_ENH] && cfg[CFG_RXDBUF]) begin
                mode = RTC_BUF_DOUBLE;
            end
        end else if (!tx && ext[EXT_GCIRC] && glob) begin
            mode = RTC_BUF_GLOBAL;
        end else if (mm != 3'h0) begin
            mode = RTC_BUF_CIRC;
        end else if (!tx && dbuf && cfg[CFG_RXDBUF]) begin
            mode = RTC_BUF_DOUBLE;
        end
        return mode;
    endfunction

    // ==========================================================
    // register bus decode
    assign cmd_wr  = WR && ADDR == REG_CMD;
    assign rd_isr1 = RD && ADDR == REG_ISR1;
    assign rd_isr2 = RD && ADDR == REG_ISR2;
    assign seen1   = st.seen1 || rd_isr1;
    assign seen2   = st.seen2 || rd_isr2;

    assign auto_release = st.cfg[CFG_AUTOCLR] && (rd_isr1 || rd_isr2)
                          && (seen1 || ISR1_DATA == 16'h0000) && (seen2 || ISR2_DATA == 16'h0000);

    // ==========================================================
    // stamp and interrupt controls
    // clear on sync
    assign ctl.stamp_clear = (cmd_wr && WDATA[CMD_STAMP_RST])
                             || (RT_MODE && SYNC_NODATA && st.msg_cfg[CFG_SYNC_CLR]);
    assign ctl.stamp_load  = RT_MODE && SYNC_DATA && st.msg_cfg[CFG_SYNC_LD];
    assign ctl.load_val    = SYNC_WORD;
    assign ctl.test_tick   = cmd_wr && WDATA[CMD_TEST_CLK];
    assign ctl.ext_tick    = st.ext_sync[1] && !st.ext_sync[2];
    assign ctl.res         = st.cfg[CFG_RES_LSB +: 3];
    assign ctl.irq_event   = IRQ_EVENT;
    assign ctl.level_mode  = st.cfg[CFG_LEVEL];
    assign ctl.irq_release = (cmd_wr && WDATA[CMD_INT_RST]) || auto_release;

    rtc_stamp u_stamp (
        .clk   (MCLK),
        .reset (RESET),
        .ctl   (ctl)
    );

    rtc_irq #(
        .PULSE_CYCLES (PULSE_CYCLES)
    ) u_irq (
        .clk   (MCLK),
        .reset (RESET),
        .ctl   (ctl)
    );

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.ext_sync = {st.ext_sync[1:0], EXT_STAMP_CLK};

        if (WR && ADDR == REG_CFG) begin
            next_st.cfg = WDATA & CFG_MASK;
        end
        if (WR && ADDR == REG_CFG_EXT) begin
            next_st.ext = WDATA & EXT_MASK;
        // flag moves only by host unless enabled
        end else if (TVW_DONE && RT_MODE && st.msg_cfg[CFG_CLRSRQ]) begin
            next_st.ext[EXT_SRQ] = 1'b0;
        end

        next_st.rdata = 16'h0000;
        if (RD) begin
            case (ADDR)
                REG_CFG:     next_st.rdata = st.cfg;
                REG_CFG_EXT: next_st.rdata = st.ext;
                REG_STAMP:   next_st.rdata = ctl.stamp_val;
                REG_ISR1:    next_st.rdata = ISR1_DATA;
                REG_ISR2:    next_st.rdata = ISR2_DATA;
                default:     next_st.rdata = 16'h0000;
            endcase
        end

        next_st.isr1_clr  = rd_isr1 && st.cfg[CFG_AUTOCLR];
        next_st.isr2_clr  = rd_isr2 && st.cfg[CFG_AUTOCLR];
        next_st.isr_reset = cmd_wr && WDATA[CMD_INT_RST];
        next_st.seen1     = seen1 && !IRQ_EVENT && !auto_release;
        next_st.seen2     = seen2 && !IRQ_EVENT && !auto_release;

        if (MSG_START) begin
            next_st.msg_cfg   = st.cfg;
            next_st.msg_ext   = st.ext;
            next_st.msg_stamp = ctl.stamp_val;
        end

        next_st.bc_stamp = !RT_MODE && st.msg_cfg[CFG_SYNC_LD];
        next_st.bc_word  = 16'h0000;
        if (!RT_MODE && st.msg_cfg[CFG_SYNC_LD]) begin
            next_st.bc_word = st.msg_ext[EXT_ENHSYNC] ? ctl.stamp_val : st.msg_stamp;
        end

        next_st.buf_mode  = buf_pick(st.msg_cfg, st.msg_ext, SA_TX, SA_MM, SA_DBUF, SA_GLOBAL);
        next_st.circ_log2 = 4'h0;
        if (next_st.buf_mode == RTC_BUF_CIRC) begin
            next_st.circ_log2 = CIRC_LOG2_BASE + {1'b0, SA_MM};
        end

        if (SA_TX) begin
            next_st.area = RTC_AREA_TX;
        end else if (SA_BCST && st.msg_cfg[CFG_SEPBC]) begin
            next_st.area = RTC_AREA_BCST;
        end else begin
            next_st.area = RTC_AREA_RX;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st         <= '0;
            st.cfg     <= CFG_RESET;
            st.ext     <= EXT_RESET;
            st.msg_cfg <= CFG_RESET;
            st.msg_ext <= EXT_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign RDATA         = st.rdata;
    assign INT_N         = ctl.int_n;
    assign ISR1_CLR      = st.isr1_clr;
    assign ISR2_CLR      = st.isr2_clr;
    assign ISR_RESET     = st.isr_reset;
    assign SRQ_STATUS    = st.ext[EXT_SRQ];
    assign BC_SYNC_STAMP = st.bc_stamp;
    assign BC_SYNC_WORD  = st.bc_word;
    assign BUF_MODE      = st.buf_mode;
    assign CIRC_LOG2     = st.circ_log2;
    assign LUT_AREA      = st.area;

    // ==========================================================
    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    sequence s_tvw_clear;
        RT_MODE && TVW_DONE && st.msg_cfg[CFG_CLRSRQ] && !(WR && ADDR == REG_CFG_EXT);
    endsequence

    AST_SYNC_CLEAR: assert property (
        RT_MODE && SYNC_NODATA && st.msg_cfg[CFG_SYNC_CLR] |=> ctl.stamp_val == 16'h0000)
        else $error("sync did not clear stamp");
    AST_SYNC_LOAD: assert property (
        ctl.stamp_load && !ctl.stamp_clear |=> ctl.stamp_val == $past(SYNC_WORD))
        else $error("sync word not loaded");
    AST_BC_SEND: assert property (
        !RT_MODE && st.msg_cfg[CFG_SYNC_LD] && st.msg_ext[EXT_ENHSYNC]
        |=> BC_SYNC_STAMP && BC_SYNC_WORD == $past(ctl.stamp_val)) else $error("bad sync data word");
    AST_ISR1_AUTOCLR: assert property (
        rd_isr1 && st.cfg[CFG_AUTOCLR] |=> ISR1_CLR && !ISR2_CLR) else $error("wrong status clear");
    AST_SRQ_MANUAL: assert property (
        !st.msg_cfg[CFG_CLRSRQ] && !(WR && ADDR == REG_CFG_EXT) |=> $stable(SRQ_STATUS))
        else $error("service request moved without host");
    AST_SRQ_AUTO: assert property (s_tvw_clear |=> !SRQ_STATUS)
        else $error("service request not cleared");
    AST_TX_NO_DOUBLE: assert property (SA_TX |=> BUF_MODE != RTC_BUF_DOUBLE)
        else $error("transmit double buffered");
    AST_BCST_AREA: assert property (
        SA_BCST && !SA_TX && st.msg_cfg[CFG_SEPBC] |=> LUT_AREA == RTC_AREA_BCST)
        else $error("broadcast area not used");
    AST_RX_AREA: assert property (
        !SA_TX && !st.msg_cfg[CFG_SEPBC] |=> LUT_AREA == RTC_AREA_RX) else $error("receive area not used");
    AST_MSG_HOLD: assert property (!MSG_START |=> $stable(st.msg_cfg))
        else $error("config changed mid message");
endmodule

// File: verification/rtc_isr_model.sv
`timescale 1ns/100ps
module rtc_isr_model (
    input  logic        clk,
    input  logic        reset,
    input  logic        raise,
    input  logic [15:0] set1,
    input  logic [15:0] set2,
    input  logic        clr1,
    input  logic        clr2,
    input  logic        clr_all,
    output logic [15:0] isr1,
    output logic [15:0] isr2,
    output logic        irq_event
);
    // ==========================================================
    // interrupt status registers outside the block
    always_ff @(posedge clk) begin
        if (reset) begin
            isr1      <= 16'h0000;
            isr2      <= 16'h0000;
            irq_event <= 1'b0;
        end else begin
            irq_event <= raise;
            isr1      <= (clr1 || clr_all) ? 16'h0000 : (raise ? isr1 | set1 : isr1);
            isr2      <= (clr2 || clr_all) ? 16'h0000 : (raise ? isr2 | set2 : isr2);
        end
    end
endmodule

// File: verification/tb_rt_timetag_irq_config.sv
`timescale 1ns/100ps
module tb_rt_timetag_irq_config import rtc_pkg::*;;
    localparam int PC = 12;
    logic        MCLK, RESET, WR, RD, RT_MODE, EXT_STAMP_CLK, IRQ_EVENT, raise;
    logic        INT_N, ISR1_CLR, ISR2_CLR, ISR_RESET, SRQ_STATUS, BC_SYNC_STAMP;
    logic [3:0]  ADDR, CIRC_LOG2, ev;
    logic [6:0]  sa;
    logic [15:0] WDATA, RDATA, SYNC_WORD, ISR1_DATA, ISR2_DATA, BC_SYNC_WORD, set1, set2, d, e;
    rtc_buf_t    BUF_MODE;
    rtc_area_t   LUT_AREA;
    int          failures = 0;
    int          compares = 0;
    int          n;

    rtc_top #(.PULSE_CYCLES(PC)) dut (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .RT_MODE(RT_MODE), .MSG_START(ev[0]), .SYNC_NODATA(ev[1]),
        .SYNC_DATA(ev[2]), .SYNC_WORD(SYNC_WORD), .TVW_DONE(ev[3]), .IRQ_EVENT(IRQ_EVENT),
        .ISR1_DATA(ISR1_DATA), .ISR2_DATA(ISR2_DATA), .EXT_STAMP_CLK(EXT_STAMP_CLK), .SA_TX(sa[6]),
        .SA_BCST(sa[5]), .SA_MM(sa[2:0]), .SA_DBUF(sa[4]), .SA_GLOBAL(sa[3]), .INT_N(INT_N),
        .ISR1_CLR(ISR1_CLR), .ISR2_CLR(ISR2_CLR), .ISR_RESET(ISR_RESET), .SRQ_STATUS(SRQ_STATUS),
        .BC_SYNC_STAMP(BC_SYNC_STAMP), .BC_SYNC_WORD(BC_SYNC_WORD), .BUF_MODE(BUF_MODE),
        .CIRC_LOG2(CIRC_LOG2), .LUT_AREA(LUT_AREA));

    rtc_isr_model isr (.clk(MCLK), .reset(RESET), .raise(raise), .set1(set1), .set2(set2), .clr1(ISR1_CLR),
        .clr2(ISR2_CLR), .clr_all(ISR_RESET), .isr1(ISR1_DATA), .isr2(ISR2_DATA), .irq_event(IRQ_EVENT));

    // ==========================================================
    // access tasks
    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge MCLK);
        @(negedge MCLK);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge MCLK);
        WR    <= 1'b1;
        ADDR  <= a;
        WDATA <= v;
        @(posedge MCLK);
        WR    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge MCLK);
        RD   <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD   <= 1'b0;
        @(negedge MCLK);
        v = RDATA;
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task automatic pe(input int i);
        @(posedge MCLK);
        ev[i] <= 1'b1;
        @(posedge MCLK);
        ev[i] <= 1'b0;
    endtask
    task automatic irq();
        @(posedge MCLK);
        raise <= 1'b1;
        @(posedge MCLK);
        raise <= 1'b0;
    endtask
    task automatic bm(input logic [15:0] c, input logic [15:0] x, input logic [6:0] s,
                      input rtc_buf_t b, input rtc_area_t ar, input logic [3:0] l);
        wr(REG_CFG, c);
        wr(REG_CFG_EXT, x);
        sa <= s;
        pe(0);
        cyc(2);
        chk({8'h00, BUF_MODE, LUT_AREA, CIRC_LOG2}, {8'h00, b, ar, l});
    endtask

    // ==========================================================
    // clock and watchdog
    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        failures++;
        final_report();
    end

    // ==========================================================
    // test sequence
    initial begin
        {RESET, RT_MODE} = 2'b11;
        {WR, RD, raise, EXT_STAMP_CLK} = 4'h0;
        {ADDR, ev, sa} = 15'h0000;
        {WDATA, SYNC_WORD, set1, set2} = 64'h0;
        repeat (6) @(posedge MCLK);
        RESET <= 1'b0;
        rc(REG_CFG, CFG_RESET);
        rc(REG_CFG_EXT, EXT_RESET);
        chk({15'h0000, INT_N}, 16'h0001);
        wr(REG_CFG, 16'hFFFF);
        rc(REG_CFG, CFG_MASK);
        wr(REG_CFG, 16'h0360);
        wr(REG_CMD, 16'h0008);
        wr(REG_CMD, 16'h0010);
        wr(REG_CMD, 16'h0010);
        cyc(100);
        rc(REG_STAMP, 16'h0002);
        pe(0);
        pe(1);
        rc(REG_STAMP, 16'h0000);
        @(posedge MCLK) SYNC_WORD <= 16'hA5C3;
        pe(2);
        rc(REG_STAMP, 16'hA5C3);
        @(posedge MCLK) RT_MODE <= 1'b0;
        wr(REG_CFG_EXT, 16'h0004);
        pe(0);
        cyc(2);
        chk({15'h0000, BC_SYNC_STAMP}, 16'h0001);
        chk(BC_SYNC_WORD, 16'hA5C3);
        wr(REG_CMD, 16'h0010);
        cyc(2);
        chk(BC_SYNC_WORD, 16'hA5C4);
        @(posedge MCLK) RT_MODE <= 1'b1;
        for (int k = 2; k < 6; k++) begin
            wr(REG_CFG, 16'(k) << CFG_RES_LSB);
            wr(REG_CMD, 16'h0008);
            cyc(1600);
            rd(REG_STAMP, d);
            e = 16'(1600 / ((STAMP_US_MAX >> k) * CLK_MHZ));
            chk({15'h0000, d + 16'h0001 >= e && d <= e + 16'h0001}, 16'h0001);
        end
        // external stamp clock: three rising edges
        wr(REG_CFG, 16'h0380);
        wr(REG_CMD, 16'h0008);
        repeat (3) begin
            @(posedge MCLK) EXT_STAMP_CLK <= 1'b1;
            repeat (2) @(posedge MCLK);
            EXT_STAMP_CLK <= 1'b0;
            repeat (2) @(posedge MCLK);
        end
        cyc(4);
        rc(REG_STAMP, 16'h0003);
        wr(REG_CFG, 16'h0000);
        irq();
        for (int i = 0; i < 8 && INT_N !== 1'b0; i++) @(negedge MCLK);
        n = 0;
        while (INT_N === 1'b0 && n < 40) begin
            @(negedge MCLK);
            n++;
        end
        chk(16'(n), 16'(PC));
        wr(REG_CFG, 16'h0018);
        set1 <= 16'h0001;
        set2 <= 16'h0002;
        irq();
        cyc(4);
        rc(REG_ISR1, 16'h0001);
        cyc(2);
        chk({15'h0000, INT_N}, 16'h0000);
        rc(REG_ISR1, 16'h0000);
        rc(REG_ISR2, 16'h0002);
        cyc(3);
        chk({15'h0000, INT_N}, 16'h0001);
        rc(REG_ISR2, 16'h0000);
        wr(REG_CFG, 16'h0008);
        irq();
        cyc(2 * PC);
        rc(REG_ISR1, 16'h0001);
        chk({15'h0000, INT_N}, 16'h0000);
        wr(REG_CMD, 16'h0004);
        cyc(2);
        chk({15'h0000, INT_N}, 16'h0001);
        rc(REG_ISR2, 16'h0000);
        wr(REG_CFG, 16'h0000);
        wr(REG_CFG_EXT, 16'h0001);
        pe(0);
        pe(3);
        cyc(1);
        chk({15'h0000, SRQ_STATUS}, 16'h0001);
        wr(REG_CFG, 16'h0004);
        pe(0);
        cyc(1);
        chk({15'h0000, SRQ_STATUS}, 16'h0001);
        pe(3);
        cyc(1);
        chk({15'h0000, SRQ_STATUS}, 16'h0000);
        rc(REG_CFG_EXT, 16'h0000);
        bm(16'h0000, 16'h0000, 7'h00, RTC_BUF_SINGLE, RTC_AREA_RX, 4'h0);
        bm(16'h0000, 16'h0000, 7'h40, RTC_BUF_SINGLE, RTC_AREA_TX, 4'h0);
        bm(16'h0000, 16'h0000, 7'h20, RTC_BUF_SINGLE, RTC_AREA_RX, 4'h0);
        bm(16'h0001, 16'h0000, 7'h20, RTC_BUF_SINGLE, RTC_AREA_BCST, 4'h0);
        wr(REG_CFG, 16'h0000);
        cyc(2);
        chk({14'h0000, LUT_AREA}, {14'h0000, RTC_AREA_BCST});
        bm(16'h1000, 16'h8000, 7'h00, RTC_BUF_DOUBLE, RTC_AREA_RX, 4'h0);
        bm(16'h1002, 16'h8000, 7'h10, RTC_BUF_DOUBLE, RTC_AREA_RX, 4'h0);
        bm(16'h1002, 16'h8000, 7'h50, RTC_BUF_SINGLE, RTC_AREA_TX, 4'h0);
        bm(16'h0002, 16'h8000, 7'h03, RTC_BUF_CIRC, RTC_AREA_RX, 4'h9);
        bm(16'h0002, 16'h8000, 7'h07, RTC_BUF_CIRC, RTC_AREA_RX, 4'hD);
        bm(16'h0002, 16'h9000, 7'h08, RTC_BUF_GLOBAL, RTC_AREA_RX, 4'h0);
        final_report();
    end
endmodule
